// ===== logic/rpr_defs.svh
// Register indices, field widths and reset values of the ramp profile registers.
// Assumes inclusion by bare name from the package and the design file.
`ifndef RPR_DEFS_SVH
`define RPR_DEFS_SVH

// ==========================================================================
// Register indices (byte address is four times the index)
`define RPR_IDX_LIVE_VEL    10'h04E
`define RPR_IDX_LIVE_ACC    10'h04F
`define RPR_IDX_START_VEL   10'h050
`define RPR_IDX_FIRST_ACC   10'h051
`define RPR_IDX_FIRST_VEL   10'h052

// ==========================================================================
// Field widths
`define RPR_VEL_W           24
`define RPR_VMAG_W          23
`define RPR_ACC_W           24
`define RPR_START_W         18
`define RPR_A1_W            18
`define RPR_TOPA_W          18
`define RPR_THR_W           20

// ==========================================================================
// Reset values
`define RPR_LIVE_VEL_RST    24'h000000
`define RPR_LIVE_ACC_RST    24'h000000
`define RPR_START_RST       18'h00000
`define RPR_A1_RST          18'h00000
`define RPR_THR_RST         20'h00000

`endif

// ===== logic/rpr_pkg.sv
// Types shared by the ramp profile register block and its surroundings.
// Assumes rpr_defs.svh is on the include path.
`include "rpr_defs.svh"

package rpr_pkg;

  // Ramp generator operating modes
  typedef enum logic [1:0] {
    RPR_POSITION,
    RPR_VEL_POS,
    RPR_VEL_NEG,
    RPR_HOLD
  } rpr_mode_t;

  // Live state and limits arriving from the ramp generator
  typedef struct packed {
    rpr_mode_t                 mode;
    logic                      moving_down;
    logic [`RPR_VMAG_W-1:0]    velocity_mag;
    logic [`RPR_ACC_W-1:0]     accel;
    logic [`RPR_TOPA_W-1:0]    top_acceleration;
    logic [`RPR_TOPA_W-1:0]    top_deceleration;
    logic [`RPR_TOPA_W-1:0]    first_deceleration;
  } rpr_ramp_in_t;

  // Early-phase profile handed back to the ramp generator
  typedef struct packed {
    logic [`RPR_START_W-1:0]   start_velocity;
    logic [`RPR_THR_W-1:0]     first_threshold_velocity;
    logic                      phase1_enable;
    logic [`RPR_TOPA_W-1:0]    phase1_accel;
    logic [`RPR_TOPA_W-1:0]    phase1_decel;
  } rpr_profile_t;

endpackage

// ===== logic/rpr_regs.sv
// Ramp profile registers of the first axis: live velocity and acceleration
// readback, start velocity, first acceleration and first threshold velocity.
// Assumes an APB master on core_clk and a ramp generator on the same clock.
`timescale 1ns/1ns
`include "rpr_defs.svh"

module rpr_regs
  import rpr_pkg::*;
(
  // Clock and reset
  input  wire logic          core_clk,
  input  wire logic          rst_n,
  // APB slave
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [11:0]   paddr,
  input  wire logic [31:0]   pwdata,
  input  wire logic [3:0]    pstrb,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  // Ramp generator side
  input  wire rpr_ramp_in_t  ramp_in,
  output rpr_profile_t       profile
);

  // ==========================================================================
  // Storage
  logic [`RPR_VEL_W-1:0]    live_velocity;
  logic [`RPR_ACC_W-1:0]    live_acceleration;
  logic [`RPR_START_W-1:0]  ramp_start_velocity;
  logic [`RPR_A1_W-1:0]     first_phase_accel;
  logic [`RPR_THR_W-1:0]    first_phase_velocity;

  // ==========================================================================
  // APB decode
  logic [9:0]   word_idx;
  logic         aligned;
  logic         hit_vel;
  logic         hit_acc;
  logic         hit_start;
  logic         hit_a1;
  logic         hit_thr;
  logic         mapped;
  logic         setup;
  logic         access;
  logic         wr_en;
  logic [31:0]  next_rdata;

  assign word_idx  = paddr[11:2];
  assign aligned   = (paddr[1:0] == 2'h0);
  assign hit_vel   = aligned && (word_idx == `RPR_IDX_LIVE_VEL);
  assign hit_acc   = aligned && (word_idx == `RPR_IDX_LIVE_ACC);
  assign hit_start = aligned && (word_idx == `RPR_IDX_START_VEL);
  assign hit_a1    = aligned && (word_idx == `RPR_IDX_FIRST_ACC);
  assign hit_thr   = aligned && (word_idx == `RPR_IDX_FIRST_VEL);
  assign mapped    = hit_vel || hit_acc || hit_start || hit_a1 || hit_thr;
  assign setup     = psel && !penable;
  assign access    = psel && penable;
  // Zero wait states: every access completes in its first access cycle
  assign pready    = 1'b1;
  assign wr_en     = access && pready && pwrite && mapped;

  // Byte-lane merge of a write into a word
  function automatic logic [31:0] rpr_merge(input logic [31:0] old_w,
                                            input logic [31:0] new_w,
                                            input logic [3:0]  strb);
    logic [31:0] res;
    res = old_w;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = new_w[b*8 +: 8];
      end
    end
    return res;
  endfunction

  always_comb begin
    next_rdata = 32'h00000000;
    // Upper bits stay zero by zero extension of each field
    unique case (1'b1)
      hit_vel:   next_rdata = {8'h00, live_velocity};
      hit_acc:   next_rdata = {8'h00, live_acceleration};
      hit_start: next_rdata = {14'h0000, ramp_start_velocity};
      hit_a1:    next_rdata = {14'h0000, first_phase_accel};
      hit_thr:   next_rdata = {12'h000, first_phase_velocity};
      default:   next_rdata = 32'h00000000;
    endcase
  end

  // Read data sampled in setup so it comes from a flop during access
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h00000000;
    end else if (setup) begin
      prdata <= pwrite ? 32'h00000000 : next_rdata;
    end
  end

  // Unmapped or unaligned addresses answer with an error
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pslverr <= 1'b0;
    end else if (setup) begin
      pslverr <= !mapped;
    end
  end

  // ==========================================================================
  // Writable profile registers
  logic [31:0] merged;
  assign merged = rpr_merge({14'h0000, ramp_start_velocity}, pwdata, pstrb);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ramp_start_velocity <= `RPR_START_RST;
    end else if (wr_en && hit_start) begin
      ramp_start_velocity <= merged[`RPR_START_W-1:0];
    end
  end

  logic [31:0] merged_a1;
  assign merged_a1 = rpr_merge({14'h0000, first_phase_accel}, pwdata, pstrb);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      first_phase_accel <= `RPR_A1_RST;
    end else if (wr_en && hit_a1) begin
      first_phase_accel <= merged_a1[`RPR_A1_W-1:0];
    end
  end

  logic [31:0] merged_thr;
  assign merged_thr = rpr_merge({12'h000, first_phase_velocity}, pwdata, pstrb);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      first_phase_velocity <= `RPR_THR_RST;
    end else if (wr_en && hit_thr) begin
      first_phase_velocity <= merged_thr[`RPR_THR_W-1:0];
    end
  end

  // ==========================================================================
  // Live readback; bus writes never reach these
  logic [`RPR_VEL_W-1:0] next_velocity;
  // Magnitude plus direction keeps the sign honest even at a zero crossing
  assign next_velocity = ramp_in.moving_down ? (-{1'b0, ramp_in.velocity_mag})
                                             : {1'b0, ramp_in.velocity_mag};

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      live_velocity <= `RPR_LIVE_VEL_RST;
    end else begin
      live_velocity <= next_velocity;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      live_acceleration <= `RPR_LIVE_ACC_RST;
    end else begin
      live_acceleration <= ramp_in.accel;
    end
  end

  // ==========================================================================
  // Early-phase profile
  logic pos_mode;
  logic phase1_on;
  assign pos_mode  = (ramp_in.mode == RPR_POSITION);
  assign phase1_on = pos_mode && (first_phase_velocity != `RPR_THR_RST);

  // Stop velocity below start velocity is left to software; no clamp here
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      profile <= '0;
    end else begin
      profile.start_velocity           <= pos_mode ? ramp_start_velocity : `RPR_START_RST;
      profile.first_threshold_velocity <= first_phase_velocity;
      profile.phase1_enable            <= phase1_on;
      if (!pos_mode) begin
        profile.phase1_accel <= ramp_in.top_acceleration;
        profile.phase1_decel <= ramp_in.top_acceleration;
      end else if (phase1_on) begin
        profile.phase1_accel <= first_phase_accel;
        profile.phase1_decel <= ramp_in.first_deceleration;
      end else begin
        profile.phase1_accel <= ramp_in.top_acceleration;
        profile.phase1_decel <= ramp_in.top_deceleration;
      end
    end
  end

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  a_vel_read_value: assert property (setup && !pwrite && hit_vel
    |=> prdata == {8'h00, $past(live_velocity)})
    else $error("velocity readback wrong");

  a_vel_sign_down: assert property (ramp_in.moving_down && (ramp_in.velocity_mag != 23'h000000)
    |=> live_velocity[23])
    else $error("downward motion not negative");

  a_vel_sign_up: assert property (!ramp_in.moving_down
    |=> !live_velocity[23] && (live_velocity[22:0] == $past(ramp_in.velocity_mag)))
    else $error("upward motion not positive");

  a_acc_read_track: assert property (1'b1 ##1 setup && !pwrite && hit_acc
    |=> prdata == {8'h00, $past(ramp_in.accel, 2)})
    else $error("acceleration readback wrong");

  a_start_write_read: assert property (wr_en && hit_start && (pstrb == 4'hF)
    |=> ramp_start_velocity == $past(pwdata[17:0]))
    else $error("start velocity write lost");

  a_start_pos_only: assert property (ramp_in.mode != RPR_POSITION
    |=> profile.start_velocity == 18'h00000)
    else $error("start velocity used outside positioning");

  a_start_pos_used: assert property (ramp_in.mode == RPR_POSITION
    |=> profile.start_velocity == $past(ramp_start_velocity))
    else $error("start velocity not applied");

  a_a1_write_use: assert property (wr_en && hit_a1 && (pstrb == 4'hF)
    |=> first_phase_accel == $past(pwdata[17:0]))
    else $error("first acceleration write lost");

  a_thr_write_read: assert property (wr_en && hit_thr && (pstrb == 4'hF) ##2 setup && !pwrite && hit_thr
    |=> prdata == {12'h000, $past(pwdata[19:0], 3)})
    else $error("threshold readback wrong");

  a_skip_first_phase: assert property ((ramp_in.mode == RPR_POSITION) && (first_phase_velocity == 20'h00000)
    |=> !profile.phase1_enable && (profile.phase1_accel == $past(ramp_in.top_acceleration))
        && (profile.phase1_decel == $past(ramp_in.top_deceleration)))
    else $error("first phase not skipped");

  a_velmode_top: assert property (ramp_in.mode inside {RPR_VEL_POS, RPR_VEL_NEG}
    |=> (profile.phase1_accel == $past(ramp_in.top_acceleration))
        && (profile.phase1_decel == $past(ramp_in.top_acceleration)))
    else $error("velocity mode not using top acceleration");

  a_upper_zero: assert property (setup && !pwrite && mapped
    |=> prdata[31:24] == 8'h00)
    else $error("upper bits not zero");

  a_ro_write_ignored: assert property (wr_en && hit_vel
    |=> live_velocity == $past(next_velocity))
    else $error("read-only register written");

  a_unmapped_err: assert property (setup && !mapped
    |=> pslverr && (prdata == 32'h00000000))
    else $error("unmapped access not refused");

  a_vel_zero_cross: assert property (ramp_in.moving_down && (ramp_in.velocity_mag == 23'h000000)
    |=> live_velocity == 24'h000000)
    else $error("downward zero velocity not zero");

  a_acc_tracks: assert property (1'b1
    |=> live_acceleration == $past(ramp_in.accel))
    else $error("live acceleration not tracking");

  a_ro_no_error: assert property (setup && pwrite && (hit_vel || hit_acc)
    |=> !pslverr)
    else $error("read-only write flagged as error");

  a_start_read_value: assert property (setup && !pwrite && hit_start
    |=> prdata == {14'h0000, $past(ramp_start_velocity)})
    else $error("start velocity readback wrong");

  a_a1_read_value: assert property (setup && !pwrite && hit_a1
    |=> prdata == {14'h0000, $past(first_phase_accel)})
    else $error("first acceleration readback wrong");

  a_start_hold: assert property (!(wr_en && hit_start)
    |=> $stable(ramp_start_velocity))
    else $error("start velocity changed without write");

  a_a1_hold: assert property (!(wr_en && hit_a1)
    |=> $stable(first_phase_accel))
    else $error("first acceleration changed without write");

  a_thr_hold: assert property (!(wr_en && hit_thr)
    |=> $stable(first_phase_velocity))
    else $error("threshold changed without write");

  a_start_lane_keep: assert property (wr_en && hit_start && !pstrb[2]
    |=> ramp_start_velocity[17:16] == $past(ramp_start_velocity[17:16]))
    else $error("unstrobed lane overwritten");

  a_phase1_values: assert property ((ramp_in.mode == RPR_POSITION) && (first_phase_velocity != 20'h00000)
    |=> profile.phase1_enable && (profile.phase1_accel == $past(first_phase_accel))
        && (profile.phase1_decel == $past(ramp_in.first_deceleration)))
    else $error("first phase values not applied");

  a_thr_to_profile: assert property (1'b1
    |=> profile.first_threshold_velocity == $past(first_phase_velocity))
    else $error("threshold not handed to ramp");

  a_write_rdata_zero: assert property (setup && pwrite
    |=> prdata == 32'h00000000)
    else $error("write cycle left read data");

  a_mapped_no_err: assert property (setup && mapped
    |=> !pslverr)
    else $error("mapped access refused");

  a_rsp_hold: assert property (!setup
    |=> $stable(prdata) && $stable(pslverr))
    else $error("response changed outside setup");

  a_unaligned_err: assert property (setup && (paddr[1:0] != 2'h0)
    |=> pslverr)
    else $error("unaligned access not refused");

  a_velmode_no_phase1: assert property (ramp_in.mode != RPR_POSITION
    |=> !profile.phase1_enable)
    else $error("first phase enabled outside positioning");

  a_hold_top: assert property (ramp_in.mode == RPR_HOLD
    |=> (profile.phase1_accel == $past(ramp_in.top_acceleration))
        && (profile.phase1_decel == $past(ramp_in.top_acceleration)))
    else $error("hold mode not using top acceleration");

  c_read_velocity: cover property (setup && !pwrite && hit_vel ##1 access && live_velocity[23]);
  c_write_threshold: cover property (wr_en && hit_thr && (pwdata[19:0] != 20'h00000));
  c_first_phase_on: cover property (profile.phase1_enable ##1 !profile.phase1_enable);
  c_velocity_mode: cover property (ramp_in.mode == RPR_VEL_NEG ##1 ramp_in.mode == RPR_POSITION);
  c_lane_write: cover property (wr_en && hit_start && (pstrb != 4'hF));

endmodule

// ===== test/ramp_profile_regs_test.sv
// Self-checking bench for the ramp profile registers: APB reads and writes,
// live readback and the early-phase profile handed to the ramp generator.
// Assumes rpr_pkg compiled first and rpr_defs.svh on the include path.
`timescale 1ns/1ns
`include "rpr_defs.svh"

module ramp_profile_regs_test
  import rpr_pkg::*;
;
  // ==========================================================================
  // Signals
  logic         core_clk;
  logic         rst_n;
  logic         psel;
  logic         penable;
  logic         pwrite;
  logic [11:0]  paddr;
  logic [31:0]  pwdata;
  logic [3:0]   pstrb;
  logic [31:0]  prdata;
  logic         pready;
  logic         pslverr;
  rpr_ramp_in_t ramp_in;
  rpr_profile_t profile;
  rpr_profile_t exp_prof;
  int           bad_count;
  int           compares;
  int           cycles;
  rpr_mode_t    vmodes [3];

  rpr_regs rpr_regs_i (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .psel     (psel),
    .penable  (penable),
    .pwrite   (pwrite),
    .paddr    (paddr),
    .pwdata   (pwdata),
    .pstrb    (pstrb),
    .prdata   (prdata),
    .pready   (pready),
    .pslverr  (pslverr),
    .ramp_in  (ramp_in),
    .profile  (profile)
  );

  // ==========================================================================
  // Clock, timeout and closing report
  always #2 core_clk = ~core_clk;

  task automatic wrap_up();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Whole run needs under a hundred cycles
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      bad_count++;
      wrap_up();
    end
  end

  // ==========================================================================
  // Bus access and comparisons
  function automatic logic [11:0] ba(input logic [9:0] idx);
    return {idx, 2'b00};
  endfunction

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                     output logic [31:0] rd, output logic err);
    @(posedge core_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic chk_reg(input string what, input logic [32:0] exp, input logic [32:0] got);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic chk_prof(input rpr_profile_t exp);
    repeat (2) @(posedge core_clk);
    compares++;
    if (profile !== exp) begin
      bad_count++;
      $display("unexpected profile: expected %h, seen %h", exp, profile);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] rd;
    logic        err;
    apb(1'b1, a, d, s, rd, err);
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic exp_err);
    logic [31:0] rd;
    logic        err;
    apb(1'b0, a, 32'h00000000, 4'h0, rd, err);
    chk_reg($sformatf("read %h", a), {exp_err, exp}, {err, rd});
  endtask

  // ==========================================================================
  // Tests
  initial begin
    core_clk = 1'b0;
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    pstrb = 4'h0;
    ramp_in = '0;
    bad_count = 0;
    compares = 0;
    cycles = 0;
    vmodes = '{RPR_VEL_POS, RPR_VEL_NEG, RPR_HOLD};
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;

    for (int i = 0; i < 5; i++) begin
      rd_chk(ba(`RPR_IDX_LIVE_VEL + 10'(i)), 32'h00000000, 1'b0);
    end
    $display("test reset_values done");

    wr(ba(`RPR_IDX_START_VEL), 32'hFFFFFFFF, 4'hF);
    wr(ba(`RPR_IDX_FIRST_ACC), 32'hFFFFFFFF, 4'hF);
    wr(ba(`RPR_IDX_FIRST_VEL), 32'hFFFFFFFF, 4'hF);
    rd_chk(ba(`RPR_IDX_START_VEL), 32'h0003FFFF, 1'b0);
    rd_chk(ba(`RPR_IDX_FIRST_ACC), 32'h0003FFFF, 1'b0);
    rd_chk(ba(`RPR_IDX_FIRST_VEL), 32'h000FFFFF, 1'b0);
    // Lane 0 only: upper bytes must keep the earlier ones
    wr(ba(`RPR_IDX_START_VEL), 32'h12345678, 4'h1);
    rd_chk(ba(`RPR_IDX_START_VEL), 32'h0003FF78, 1'b0);
    $display("test write_masks done");

    @(posedge core_clk);
    ramp_in.moving_down  <= 1'b1;
    ramp_in.velocity_mag <= 23'h000005;
    ramp_in.accel        <= 24'hABCDEF;
    wr(ba(`RPR_IDX_LIVE_VEL), 32'hFFFFFFFF, 4'hF);
    wr(ba(`RPR_IDX_LIVE_ACC), 32'h00000000, 4'hF);
    rd_chk(ba(`RPR_IDX_LIVE_VEL), 32'h00FFFFFB, 1'b0);
    rd_chk(ba(`RPR_IDX_LIVE_ACC), 32'h00ABCDEF, 1'b0);
    @(posedge core_clk);
    ramp_in.moving_down  <= 1'b0;
    ramp_in.velocity_mag <= 23'h7FFFFF;
    rd_chk(ba(`RPR_IDX_LIVE_VEL), 32'h007FFFFF, 1'b0);
    $display("test live_readback done");

    rd_chk(ba(10'h053), 32'h00000000, 1'b1);
    rd_chk(ba(`RPR_IDX_START_VEL) | 12'h001, 32'h00000000, 1'b1);
    $display("test refused_access done");

    // No stop velocity is driven here, so none can undercut start velocity
    @(posedge core_clk);
    ramp_in.mode               <= RPR_POSITION;
    ramp_in.top_acceleration   <= 18'h11111;
    ramp_in.top_deceleration   <= 18'h22222;
    ramp_in.first_deceleration <= 18'h33333;
    exp_prof = '{start_velocity: 18'h3FF78, first_threshold_velocity: 20'hFFFFF, phase1_enable: 1'b1,
                 phase1_accel: 18'h3FFFF, phase1_decel: 18'h33333};
    chk_prof(exp_prof);
    // Every non-positioning mode drops start velocity and the first phase
    foreach (vmodes[i]) begin
      ramp_in.mode <= vmodes[i];
      exp_prof = '{start_velocity: 18'h00000, first_threshold_velocity: 20'hFFFFF, phase1_enable: 1'b0,
                   phase1_accel: 18'h11111, phase1_decel: 18'h11111};
      chk_prof(exp_prof);
    end
    ramp_in.mode <= RPR_POSITION;
    wr(ba(`RPR_IDX_FIRST_VEL), 32'h00000000, 4'hF);
    rd_chk(ba(`RPR_IDX_FIRST_VEL), 32'h00000000, 1'b0);
    exp_prof = '{start_velocity: 18'h3FF78, first_threshold_velocity: 20'h00000, phase1_enable: 1'b0,
                 phase1_accel: 18'h11111, phase1_decel: 18'h22222};
    chk_prof(exp_prof);
    $display("test profile_modes done");

    wrap_up();
  end

endmodule
